// *** flash_array_model.sv ***
/*
 Behavioural model of the flash array behind one interface instance.
 Assumes strobes from the interface on the system clock, 1K main words.
*/
`timescale 1ns/1ns
module flash_array_model (
    input  wire logic        i_clk,       // System clock
    input  wire logic        i_row_en,    // Row enable
    input  wire logic        i_col_en,    // Column enable
    input  wire logic        i_sense_en,  // Sense amp enable
    input  wire logic        i_out_en,    // Output enable
    input  wire logic        i_prog,      // Program strobe
    input  wire logic        i_erase,     // Erase strobe
    input  wire logic        i_whole_sel, // Whole array select
    input  wire logic        i_hv_strobe, // High voltage strobe
    input  wire logic        i_info_sel,  // Info block select
    input  wire logic [15:0] i_addr,      // Word address
    input  wire logic [15:0] i_din,       // Write data
    output logic      [15:0] o_dout       // Read data
);
    logic [15:0] main_mem [0:1023];
    logic [15:0] info_mem [0:63];
    logic [15:0] idle_pat = 16'h5A5A;
    // Array starts erased
    initial begin
        foreach (main_mem[i]) main_mem[i] = 16'hFFFF;
        foreach (info_mem[i]) info_mem[i] = 16'hFFFF;
    end
    always @(posedge i_clk) begin
        idle_pat <= ~idle_pat;
        if (i_erase && i_hv_strobe) begin
            foreach (main_mem[i])
                if (i_whole_sel || (!i_info_sel &&
                    (i >> 8) == int'(i_addr[9:8])))
                    main_mem[i] <= 16'hFFFF;
            if (i_info_sel)
                foreach (info_mem[j]) info_mem[j] <= 16'hFFFF;
        end else if (i_prog && i_hv_strobe && i_col_en) begin
            if (i_info_sel)
                info_mem[i_addr[5:0]] <= info_mem[i_addr[5:0]] & i_din;
            else
                main_mem[i_addr[9:0]] <= main_mem[i_addr[9:0]] & i_din;
        end
    end
    // Read path; pattern toggles when not read
    always_comb begin
        if (i_row_en && i_col_en && i_sense_en && i_out_en)
            o_dout = i_info_sel ? info_mem[i_addr[5:0]]
                                : main_mem[i_addr[9:0]];
        else
            o_dout = idle_pat;
    end
endmodule

// *** flash_if.sv ***
/*
 Embedded flash interface unit: APB registers, interval sequencer and array
 strobe encoder for one 16-bit flash array instance.
 Assumes an APB master on I_REF_CLK and a unit-select input that marks
 this instance as the active one.
*/
// Summary of operation
// - Register writes are ignored unless this instance is the active one.
// - Same register layout in every instance, control at offset zero.
// - Upper program-array instance is this same module, different base.
// - Array split into main block and information block at start.
// - Info address: bits 0-4 word, bit 5 row, bits 6-15 zero.
// - Page erase clears eight 32-word rows, or both info rows.
// - Array strobes encoded per mode; standby drives all of them low except info select.
// - Info select routes operations; mass erase with it hits both.
// - Control, enables, address, data, irq, divisor, eight time limits.
// - Sequencer times setup, program, hold, erase and recovery intervals.
// - Default limits meet 20 us program, 40 ms, 100 ms erases.
// - Data-array instance is this same single-port module.
// - Erase sets bits to one; program only clears bits.
// - Array returns to standby when no operation is running.
`timescale 1ns/1ns
`include "flash_if_params.svh"

module flash_if #(
    parameter int AW       = 16,        // Array word address width
    parameter int LIMIT_W  = 24,        // Width of time-limit registers
    parameter logic [23:0] T_ERASE_CYC = 24'(`CYC(`T_ERASE_US)),
    parameter logic [23:0] T_ME_CYC    = 24'(`CYC(`T_ME_US))
) (
    input  wire logic          I_REF_CLK,   // System clock 20 MHz
    input  wire logic          I_RST,       // Async reset, high
    input  wire logic          I_UNIT_ACT,  // This instance is active
    input  wire logic          I_PSEL,      // APB select
    input  wire logic          I_PENABLE,   // APB access phase
    input  wire logic          I_PWRITE,    // APB direction
    input  wire logic [11:0]   I_PADDR,     // APB byte address
    input  wire logic [31:0]   I_PWDATA,    // APB write data
    output logic      [31:0]   O_PRDATA,    // APB read data
    output logic               O_PREADY,    // APB ready
    output logic               O_PSLVERR,   // APB error
    input  wire logic          I_RD_REQ,    // Core read request
    input  wire logic [AW-1:0] I_RD_ADDR,   // Core read address
    input  wire logic [15:0]   I_ARR_DOUT,  // Array read data
    output logic      [15:0]   O_RD_DATA,   // Read data to core
    output logic      [AW-1:0] O_ARR_ADDR,  // Array address
    output logic      [15:0]   O_ARR_DIN,   // Array write data
    output logic               O_ROW_EN,    // row_enable
    output logic               O_COL_EN,    // column_enable
    output logic               O_SENSE_EN,  // sense_amp_enable
    output logic               O_OUT_EN,    // Array output enable
    output logic               O_PROG,      // Program strobe
    output logic               O_ERASE,     // Erase strobe
    output logic               O_WHOLE_SEL, // whole_array_select
    output logic               O_HV_STROBE, // high_voltage_strobe
    output logic               O_INFO_SEL,  // info_block_select
    output logic               O_IRQ        // Level interrupt
);
    flash_if_pkg::seq_t  st_ff, nxt_st;
    flash_if_pkg::mode_t mode_ff, nxt_mode;
    logic [15:0]  ctrl_ff, nxt_ctrl, wren_ff, nxt_wren, div_ff, nxt_div;
    logic [15:0]  wipe_ff, nxt_wipe, addr_ff, nxt_addr, rd_ff, nxt_rd;
    logic [15:0]  data_ff, nxt_data, irqen_ff, nxt_irqen;
    logic [15:0]  irqsrc_ff, nxt_irqsrc, pre_ff, nxt_pre;
    logic [LIMIT_W-1:0] lim_ff [8];
    logic [LIMIT_W-1:0] nxt_lim [8];
    logic [LIMIT_W-1:0] cnt_ff, nxt_cnt;
    logic [31:0]  prdata_ff, nxt_prdata;
    logic         tick, wr_acc, rd_acc, hit, busy, done_ev;
    logic         range_ev, busyrd_ev, info_mode;
    logic [3:0]   lim_sel;
    logic [LIMIT_W-1:0] cur_lim;
    default clocking chk_cb @(posedge I_REF_CLK); endclocking // Checks
    default disable iff (I_RST);

    assign wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
    assign rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE;
    assign busy   = (st_ff != flash_if_pkg::ST_IDLE);
    assign info_mode = ctrl_ff[`CTRL_INFO];
    assign O_PREADY  = 1'b1;
    assign O_PRDATA  = prdata_ff;

    // Address decode, unmapped offsets answer with error
    // one shared map
    always_comb begin
        hit = 1'b1;
        case (I_PADDR)
            `OFS_CTRL, `OFS_WREN, `OFS_WIPEEN, `OFS_ADDR, `OFS_DATA,
            `OFS_IRQEN, `OFS_IRQSRC, `OFS_IRQPEND, `OFS_PRESCALE,
            `OFS_T_ERASE, `OFS_T_ME, `OFS_T_NVS, `OFS_T_PGS,
            `OFS_T_PROG, `OFS_T_NVH, `OFS_T_NVHL, `OFS_T_RCV,
            `OFS_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~hit;
    assign lim_sel   = 4'(I_PADDR[5:2] - 4'h9);

    // Prescaler: one-cycle tick every divisor+1 clocks
    // prescaled timer base
    always_comb begin
        tick = (div_ff == pre_ff);
        nxt_div = (tick || !busy) ? 16'h0000 : div_ff + 16'h0001;
    end

    // Limit for the current interval
    // interval selection
    always_comb begin
        case (st_ff)
            flash_if_pkg::ST_NVS:   cur_lim = lim_ff[2];
            flash_if_pkg::ST_PGS:   cur_lim = lim_ff[3];
            flash_if_pkg::ST_PROG:  cur_lim = lim_ff[4];
            flash_if_pkg::ST_ERASE: cur_lim =
                (mode_ff == flash_if_pkg::MODE_MASS_ERASE) ?
                lim_ff[1] : lim_ff[0];
            flash_if_pkg::ST_NVH:   cur_lim =
                (mode_ff == flash_if_pkg::MODE_MASS_ERASE) ?
                lim_ff[6] : lim_ff[5];
            flash_if_pkg::ST_RCV:   cur_lim = lim_ff[7];
            default:                cur_lim = '0;
        endcase
    end

    // Sequencer next state and interval counter
    always_comb begin
        nxt_st   = st_ff;
        nxt_mode = mode_ff;
        nxt_cnt  = cnt_ff;
        done_ev  = 1'b0;
        if (st_ff == flash_if_pkg::ST_IDLE) begin
            nxt_cnt = '0;
            nxt_mode = I_RD_REQ ? flash_if_pkg::MODE_READ :
                                  flash_if_pkg::MODE_STANDBY;
            if (I_UNIT_ACT && wr_acc && I_PADDR == `OFS_WREN &&
                I_PWDATA[`EN_START]) begin
                nxt_mode = flash_if_pkg::MODE_PROGRAM;
                nxt_st   = flash_if_pkg::ST_NVS;
            end else if (I_UNIT_ACT && wr_acc && I_PADDR == `OFS_WIPEEN &&
                         I_PWDATA[`EN_START]) begin
                nxt_mode = I_PWDATA[`EN_MASS] ?
                    flash_if_pkg::MODE_MASS_ERASE :
                    flash_if_pkg::MODE_PAGE_ERASE;
                nxt_st   = flash_if_pkg::ST_NVS;
            end
        end else if (tick) begin
            if (cnt_ff >= cur_lim) begin
                nxt_cnt = '0;
                case (st_ff)
                    flash_if_pkg::ST_NVS: nxt_st =
                        (mode_ff == flash_if_pkg::MODE_PROGRAM) ?
                        flash_if_pkg::ST_PGS : flash_if_pkg::ST_ERASE;
                    flash_if_pkg::ST_PGS:   nxt_st = flash_if_pkg::ST_PROG;
                    flash_if_pkg::ST_PROG:  nxt_st = flash_if_pkg::ST_NVH;
                    flash_if_pkg::ST_ERASE: nxt_st = flash_if_pkg::ST_NVH;
                    flash_if_pkg::ST_NVH:   nxt_st = flash_if_pkg::ST_RCV;
                    flash_if_pkg::ST_RCV: begin
                        nxt_st   = flash_if_pkg::ST_IDLE;
                        nxt_mode = flash_if_pkg::MODE_STANDBY;
                        done_ev  = 1'b1;
                    end
                    default: nxt_st = flash_if_pkg::ST_IDLE;
                endcase
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    // Core read path: info row range check and busy refusal
    // info address checks
    always_comb begin
        range_ev  = I_RD_REQ && !busy && info_mode &&
                    (I_RD_ADDR[AW-1:`INFO_ROW_BIT+1] != '0);
        busyrd_ev = I_RD_REQ && busy;
        nxt_rd    = (mode_ff == flash_if_pkg::MODE_READ) ? I_ARR_DOUT : rd_ff;
    end

    // Register file next values
    // full register set
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_wren  = wren_ff;
        nxt_wipe  = wipe_ff;
        nxt_addr  = addr_ff;
        nxt_data  = data_ff;
        nxt_irqen = irqen_ff;
        nxt_pre   = pre_ff;
        nxt_lim   = lim_ff;
        nxt_irqsrc = irqsrc_ff;
        nxt_prdata = prdata_ff;
        // writes only to the active unit
        if (wr_acc && I_UNIT_ACT && !busy) begin
            case (I_PADDR)
                `OFS_CTRL:     nxt_ctrl  = I_PWDATA[15:0] & 16'h0001;
                `OFS_WREN:     nxt_wren  = I_PWDATA[15:0];
                `OFS_WIPEEN:   nxt_wipe  = I_PWDATA[15:0];
                `OFS_ADDR:     nxt_addr  = I_PWDATA[15:0];
                `OFS_DATA:     nxt_data  = I_PWDATA[15:0];
                `OFS_IRQEN:    nxt_irqen = I_PWDATA[15:0];
                `OFS_PRESCALE: nxt_pre   = I_PWDATA[15:0];
                default: begin
                    if (I_PADDR >= `OFS_T_ERASE && I_PADDR <= `OFS_T_RCV)
                        nxt_lim[lim_sel[2:0]] = I_PWDATA[LIMIT_W-1:0];
                end
            endcase
        end
        // Reading the source register clears it; new events win
        if (rd_acc && I_PADDR == `OFS_IRQSRC)
            nxt_irqsrc = 16'h0000;
        nxt_irqsrc[`IRQ_DONE]   = nxt_irqsrc[`IRQ_DONE]   | done_ev;
        nxt_irqsrc[`IRQ_RANGE]  = nxt_irqsrc[`IRQ_RANGE]  | range_ev;
        nxt_irqsrc[`IRQ_BUSYRD] = nxt_irqsrc[`IRQ_BUSYRD] | busyrd_ev;
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            case (I_PADDR)
                `OFS_CTRL:    nxt_prdata = {16'h0000, busy, ctrl_ff[14:0]};
                `OFS_WREN:    nxt_prdata = {16'h0000, wren_ff};
                `OFS_WIPEEN:  nxt_prdata = {16'h0000, wipe_ff};
                `OFS_ADDR:    nxt_prdata = {16'h0000, addr_ff};
                `OFS_DATA:    nxt_prdata = {16'h0000, data_ff};
                `OFS_IRQEN:   nxt_prdata = {16'h0000, irqen_ff};
                `OFS_IRQSRC:  nxt_prdata = {16'h0000, irqsrc_ff};
                `OFS_IRQPEND: nxt_prdata = {16'h0000, irqsrc_ff & irqen_ff};
                `OFS_PRESCALE: nxt_prdata = {16'h0000, pre_ff};
                `OFS_STATUS:  nxt_prdata = {28'h000_0000, 1'b0, st_ff[2:0]};
                default: begin
                    nxt_prdata = 32'h0000_0000;
                    if (I_PADDR >= `OFS_T_ERASE && I_PADDR <= `OFS_T_RCV)
                        nxt_prdata = 32'(lim_ff[lim_sel[2:0]]);
                end
            endcase
        end
    end

    // All state registers; limits reset to safe defaults
    // default interval limits
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            st_ff     <= flash_if_pkg::ST_IDLE;
            mode_ff   <= flash_if_pkg::MODE_STANDBY;
            ctrl_ff   <= 16'h0000;
            wren_ff   <= 16'h0000;
            wipe_ff   <= 16'h0000;
            addr_ff   <= 16'h0000;
            data_ff   <= 16'h0000;
            irqen_ff  <= 16'h0000;
            irqsrc_ff <= 16'h0000;
            pre_ff    <= 16'h0000;
            div_ff    <= 16'h0000;
            cnt_ff    <= '0;
            rd_ff     <= 16'h0000;
            prdata_ff <= 32'h0000_0000;
            lim_ff[0] <= LIMIT_W'(T_ERASE_CYC);
            lim_ff[1] <= LIMIT_W'(T_ME_CYC);
            lim_ff[2] <= LIMIT_W'(`CYC(`T_SHORT_US));
            lim_ff[3] <= LIMIT_W'(`CYC(`T_SHORT_US));
            lim_ff[4] <= LIMIT_W'(`CYC(`T_PROG_US));
            lim_ff[5] <= LIMIT_W'(`CYC(`T_SHORT_US));
            lim_ff[6] <= LIMIT_W'(`CYC(`T_ME_US));
            lim_ff[7] <= LIMIT_W'(`CYC(`T_SHORT_US));
        end else begin
            st_ff     <= nxt_st;
            mode_ff   <= nxt_mode;
            ctrl_ff   <= nxt_ctrl;
            wren_ff   <= nxt_wren;
            wipe_ff   <= nxt_wipe;
            addr_ff   <= nxt_addr;
            data_ff   <= nxt_data;
            irqen_ff  <= nxt_irqen;
            irqsrc_ff <= nxt_irqsrc;
            pre_ff    <= nxt_pre;
            div_ff    <= nxt_div;
            cnt_ff    <= nxt_cnt;
            rd_ff     <= nxt_rd;
            prdata_ff <= nxt_prdata;
            lim_ff    <= nxt_lim;
        end
    end

    // Array strobe encoding per mode and interval
    // strobe truth table
    always_comb begin
        O_ROW_EN = 1'b0; O_COL_EN = 1'b0; O_SENSE_EN = 1'b0;
        O_OUT_EN = 1'b0; O_PROG = 1'b0; O_ERASE = 1'b0;
        O_WHOLE_SEL = 1'b0; O_HV_STROBE = 1'b0;
        case (mode_ff)
            flash_if_pkg::MODE_READ: begin
                O_ROW_EN = 1'b1; O_COL_EN = 1'b1;
                O_SENSE_EN = 1'b1; O_OUT_EN = 1'b1;
            end
            flash_if_pkg::MODE_PROGRAM: begin
                O_ROW_EN = (st_ff != flash_if_pkg::ST_RCV);
                O_PROG = (st_ff == flash_if_pkg::ST_NVS) ||
                         (st_ff == flash_if_pkg::ST_PGS) ||
                         (st_ff == flash_if_pkg::ST_PROG);
                O_COL_EN = (st_ff == flash_if_pkg::ST_PROG);
                O_HV_STROBE = O_ROW_EN && (st_ff != flash_if_pkg::ST_NVS);
            end
            flash_if_pkg::MODE_PAGE_ERASE,
            flash_if_pkg::MODE_MASS_ERASE: begin
                O_ROW_EN = (st_ff != flash_if_pkg::ST_RCV);
                O_ERASE  = (st_ff == flash_if_pkg::ST_NVS) ||
                           (st_ff == flash_if_pkg::ST_ERASE);
                O_WHOLE_SEL = O_ROW_EN &&
                    (mode_ff == flash_if_pkg::MODE_MASS_ERASE);
                O_HV_STROBE = O_ROW_EN && (st_ff != flash_if_pkg::ST_NVS);
            end
            default: ;
        endcase
    end
    assign O_INFO_SEL = info_mode;
    assign O_ARR_ADDR = (mode_ff == flash_if_pkg::MODE_READ) ? I_RD_ADDR :
                        AW'(addr_ff);
    assign O_ARR_DIN  = data_ff;
    assign O_RD_DATA  = rd_ff;
    assign O_IRQ      = |(irqsrc_ff & irqen_ff);

    // Strobe legality, write blocking and event checks
    a_idle_standby: assert property (!busy |-> !O_PROG && !O_ERASE)
        else $error("strobe while idle");
    a_hv_after_nvs: assert property ($rose(O_HV_STROBE) |->
        $past(st_ff) == flash_if_pkg::ST_NVS) else $error("hv rose early");
    a_inactive_nowrite: assert property (wr_acc && !I_UNIT_ACT &&
        I_PADDR == `OFS_DATA |=> $stable(data_ff)) else $error("write taken");
    a_prog_erase_excl: assert property (!(O_PROG && O_ERASE))
        else $error("program and erase strobes together");
    a_whole_in_erase: assert property (O_WHOLE_SEL |->
        O_ROW_EN && !O_PROG) else $error("stray whole select");
    a_done_irq: assert property (done_ev |=> irqsrc_ff[`IRQ_DONE])
        else $error("done event lost");
    cov_program: cover property (O_PROG && O_COL_EN && O_HV_STROBE);
    cov_mass: cover property (O_WHOLE_SEL && O_HV_STROBE);
    cov_busyrd: cover property (busyrd_ev);
endmodule

// *** flash_if_params.svh ***
/*
 Constants for the embedded flash interface: register offsets, field
 positions, reset values and timing figures.
 Assumes inclusion by bare name from the interface design and the bench.
*/
`ifndef FLASH_IF_PARAMS_SVH
`define FLASH_IF_PARAMS_SVH

// Register byte offsets on APB
`define OFS_CTRL      12'h000
`define OFS_WREN      12'h004
`define OFS_WIPEEN    12'h008
`define OFS_ADDR      12'h00C
`define OFS_DATA      12'h010
`define OFS_IRQEN     12'h014
`define OFS_IRQSRC    12'h018
`define OFS_IRQPEND   12'h01C
`define OFS_PRESCALE  12'h020
`define OFS_T_ERASE   12'h024
`define OFS_T_ME      12'h028
`define OFS_T_NVS     12'h02C
`define OFS_T_PGS     12'h030
`define OFS_T_PROG    12'h034
`define OFS_T_NVH     12'h038
`define OFS_T_NVHL    12'h03C
`define OFS_T_RCV     12'h040
`define OFS_STATUS    12'h044

// Control register fields
`define CTRL_INFO     0
`define CTRL_BUSY     15
// Enable register fields
`define EN_START      0
`define EN_MASS       1
// Info-row address bits
`define INFO_ROW_BIT  5

// Interrupt source bits
`define IRQ_DONE      0
`define IRQ_RANGE     1
`define IRQ_BUSYRD    2

// Timing figures (microseconds) and clock rate
`define CLK_MHZ       20
`define T_PROG_US     20
`define T_ERASE_US    40000
`define T_ME_US       100000
`define T_SHORT_US    10
`define CYC(us)       ((us) * `CLK_MHZ)

`endif

// *** flash_if_pkg.sv ***
/*
 Types for the embedded flash interface.
 Assumes nothing beyond the constants header.
*/
package flash_if_pkg;
    typedef enum logic [2:0] {
        MODE_STANDBY,
        MODE_READ,
        MODE_PROGRAM,
        MODE_PAGE_ERASE,
        MODE_MASS_ERASE
    } mode_t;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_NVS,
        ST_PGS,
        ST_PROG,
        ST_ERASE,
        ST_NVH,
        ST_RCV
    } seq_t;
endpackage

// *** tb.sv ***
/*
 Self-checking bench for the flash interface with an array model.
 Assumes APB ready within the bench timeout and idle state code zero.
*/
`timescale 1ns/1ns
`include "flash_if_params.svh"
module tb;
    logic        clk = 0, rst = 1, act = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] padr = 0;
    logic [31:0] pwd = 0, prd, r;
    logic        rdy, err, e, rdq = 0, bad;
    logic [15:0] rda = 0, adout, rdd, aadr, adin, d;
    logic        row, col, sen, oen, prg, ers, whl, hvs, inf, irq;
    logic [23:0] lim [8];
    logic [15:0] sh [0:2047];
    int          bad_count = 0, checked = 0, cyc = 0, seed = 11;
    int          pc = 0, ec = 0, p0, pre, inf_b = 0;
    always #25 clk = ~clk;
    flash_if uut (.I_REF_CLK(clk), .I_RST(rst), .I_UNIT_ACT(act),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(padr),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .I_RD_REQ(rdq), .I_RD_ADDR(rda), .I_ARR_DOUT(adout),
        .O_RD_DATA(rdd), .O_ARR_ADDR(aadr), .O_ARR_DIN(adin),
        .O_ROW_EN(row), .O_COL_EN(col), .O_SENSE_EN(sen), .O_OUT_EN(oen),
        .O_PROG(prg), .O_ERASE(ers), .O_WHOLE_SEL(whl),
        .O_HV_STROBE(hvs), .O_INFO_SEL(inf), .O_IRQ(irq));
    flash_array_model arr (.i_clk(clk), .i_row_en(row), .i_col_en(col),
        .i_sense_en(sen), .i_out_en(oen), .i_prog(prg), .i_erase(ers),
        .i_whole_sel(whl), .i_hv_strobe(hvs), .i_info_sel(inf),
        .i_addr(aadr), .i_din(adin), .o_dout(adout));
    task automatic chk(input string n, input logic [31:0] x, y);
        checked++;
        if (y !== x) begin
            $display("Error %s expected %h seen %h", n, x, y);
            bad_count++;
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Mode legality, strobe cycle counts and timeout
    always @(posedge clk) begin
        cyc <= cyc + 1;
        bad = ((prg || ers) && (!row || sen || oen)) || (prg && ers)
            || (whl && (!row || prg));
        if (prg || ers || whl) chk("mode encoding", 0, bad);
        pc <= pc + (prg && hvs && col);
        ec <= ec + (ers && hvs);
        if (cyc == 40000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        padr <= a;
        pwd <= v;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        r = prd;
        e = err;
        psel <= 0;
        pen <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] v);
        apb(1, a, v);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] x, input string n);
        apb(0, a, 0);
        chk(n, x, r);
    endtask
    task idle;
        do apb(0, `OFS_STATUS, 0); while (r[3:0] !== 4'h0);
    endtask
    task core_rd(input logic [15:0] a);
        @(posedge clk);
        rdq <= 1;
        rda <= a;
        repeat (3) @(posedge clk);
        chk("core read", sh[{inf_b[0], a[9:0]}], rdd);
        rdq <= 0;
    endtask
    task prog(input logic [15:0] a, input logic [15:0] v);
        wr(`OFS_ADDR, a);
        wr(`OFS_DATA, v);
        p0 = pc;
        wr(`OFS_WREN, 1);
        idle();
        chk("prog time", 1, pc - p0 == (lim[4] + 1) * (pre + 1));
        sh[{inf_b[0], a[9:0]}] &= v;
        core_rd(a);
    endtask
    task wipe(input logic [15:0] a, input int v, input int k);
        wr(`OFS_ADDR, a);
        p0 = ec;
        wr(`OFS_WIPEEN, v);
        idle();
        chk("erase time", 1, ec - p0 == (lim[k] + 1) * (pre + 1));
    endtask
    initial begin
        foreach (sh[i]) sh[i] = 16'hFFFF;
        repeat (6) @(posedge clk);
        rst <= 0;
        act <= 1;
        rd(`OFS_STATUS, 0, "status reset");
        rd(`OFS_IRQSRC, 0, "irq source reset");
        chk("idle strobes", 0, {row, col, sen, oen, prg, ers, hvs});
        apb(0, 12'h100, 0);
        chk("unmapped error", 1, e);
        apb(0, `OFS_CTRL, 0);
        chk("control error", 0, e);
        // Default timing program, write while busy dropped
        wr(`OFS_ADDR, 16'h0010);
        wr(`OFS_DATA, 16'hA5C3);
        wr(`OFS_IRQEN, 1);
        p0 = pc;
        wr(`OFS_WREN, 1);
        wr(`OFS_DATA, 0);
        rdq <= 1;
        @(posedge clk);
        rdq <= 0;
        idle();
        chk("default prog", 1, pc - p0 >= `CYC(`T_PROG_US));
        rd(`OFS_DATA, 16'hA5C3, "busy write");
        chk("irq raised", 1, irq);
        rd(`OFS_IRQSRC, 5, "irq done");
        rd(`OFS_IRQSRC, 0, "irq cleared");
        chk("irq low", 0, irq);
        sh[16] = 16'hA5C3;
        core_rd(16'h0010);
        // Random short limits and divisor
        pre = $random(seed) & 1;
        wr(`OFS_PRESCALE, pre);
        foreach (lim[k]) begin
            lim[k] = 2 + ($random(seed) & 3);
            wr(`OFS_T_ERASE + 4 * k, lim[k]);
        end
        foreach (lim[k]) rd(`OFS_T_ERASE + 4 * k, lim[k], "limit");
        prog(16'h0010, $random(seed));
        prog(16'h00FF, $random(seed));
        prog(16'h0200, $random(seed));
        repeat (3) prog(16'h0100 | ($random(seed) & 8'hFF), $random(seed));
        wipe(16'h0180, 1, 0);
        for (int i = 256; i < 512; i++) sh[i] = 16'hFFFF;
        core_rd(16'h0100);
        core_rd(16'h00FF);
        core_rd(16'h0200);
        // Information block, upper row
        wr(`OFS_CTRL, 1);
        @(negedge clk);
        chk("info select", 1, inf);
        inf_b = 1;
        prog(16'h0025, 16'h3C00);
        inf_b = 0;
        wr(`OFS_CTRL, 0);
        core_rd(16'h0025);
        // Masked mass erase of both blocks
        wr(`OFS_IRQEN, 0);
        rd(`OFS_IRQSRC, 1, "irq sticky");
        wr(`OFS_CTRL, 1);
        wipe(16'h0000, 3, 1);
        chk("irq masked", 0, irq);
        rd(`OFS_IRQSRC, 1, "masked source");
        foreach (sh[i]) sh[i] = 16'hFFFF;
        inf_b = 1;
        core_rd(16'h0025);
        core_rd(16'h0045);
        rd(`OFS_IRQSRC, 2, "range event");
        inf_b = 0;
        wr(`OFS_CTRL, 0);
        core_rd(16'h0010);
        // Inactive unit ignores writes
        d = $random(seed);
        wr(`OFS_DATA, d);
        act <= 0;
        wr(`OFS_DATA, ~d);
        rd(`OFS_DATA, d, "inactive write");
        act <= 1;
        report_and_stop();
    end
endmodule
